// ### awdsr_pkg.sv
// Shared constants for the alert, watchdog and diagnostic select register bank
package awdsr_pkg;
	// ****************************************
	// Register map (8-bit address field of a frame)
	// ****************************************
	localparam logic [7:0] ADDR_DIAG_SEL = 8'h3a;
	localparam logic [7:0] ADDR_WD_CFG = 8'h3b;
	localparam logic [7:0] ADDR_WD_STAT = 8'h3c;
	localparam logic [7:0] ADDR_DEB_CFG = 8'h3d;
	localparam logic [7:0] ADDR_DIN_STATE = 8'h3e;
	localparam logic [7:0] ADDR_ALERT = 8'h3f;
	// ****************************************
	// Reset values and field positions
	// ****************************************
	localparam logic [15:0] RST_DIAG_SEL = 16'h0000;
	localparam logic [4:0] RST_WD_CFG = 5'h09;
	localparam logic [15:0] RST_DEB_CFG = 16'h0010;
	localparam int WD_EN_BIT = 4;
	localparam int AL_ADC_BIT = 5;
	localparam int AL_TEMP_BIT = 4;
	localparam int AL_SPI_BIT = 3;
	localparam int AL_SUPPLY_BIT = 2;
	localparam int AL_RESET_BIT = 0;
	// ****************************************
	// Source codes of a diagnostic slot
	// ****************************************
	localparam logic [3:0] SRC_GROUND = 4'h0;
	localparam logic [3:0] SRC_LAST = 4'hd;
	// ****************************************
	// Frame format: {read, 7 spare, addr, data, check}
	// ****************************************
	localparam logic [5:0] FRAME_BITS = 6'h28;
	localparam int FRAME_RD_BIT = 39;
	localparam logic [7:0] CRC_POLY = 8'h07;
	// ****************************************
	// Watchdog timing
	// ****************************************
	localparam int CORE_CLK_NS = 8;
	localparam int WD_TICK_NS = 1000000;
	localparam int WD_TICK_CYCLES = WD_TICK_NS / CORE_CLK_NS;
	localparam logic [10:0] WD_T_1MS = 11'h001;
	localparam logic [10:0] WD_T_5MS = 11'h005;
	localparam logic [10:0] WD_T_10MS = 11'h00a;
	localparam logic [10:0] WD_T_25MS = 11'h019;
	localparam logic [10:0] WD_T_50MS = 11'h032;
	localparam logic [10:0] WD_T_100MS = 11'h064;
	localparam logic [10:0] WD_T_250MS = 11'h0fa;
	localparam logic [10:0] WD_T_500MS = 11'h1f4;
	localparam logic [10:0] WD_T_750MS = 11'h2ee;
	localparam logic [10:0] WD_T_1S = 11'h3e8;
	localparam logic [10:0] WD_T_2S = 11'h7d0;
	// Modem status bits that never raise the summary (carrier, frame monitor)
	localparam logic [15:0] MODEM_IGNORE = 16'h0003;
endpackage

// ### awdsr_regs.sv
// Alert summary, watchdog, debounced input and diagnostic select registers
`timescale 1ns/10ps
module awdsr_regs
	import awdsr_pkg::*;
#(
	parameter int TICK_CYCLES = WD_TICK_CYCLES, // Core cycles per watchdog millisecond
	parameter logic [15:0] MODEM_SKIP = MODEM_IGNORE // Modem fields left out of summary
) (
	input wire logic core_clk, // Core clock, 125 MHz
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic spi_sclk, // Serial clock from host
	input wire logic spi_cs_n, // Frame select, active low
	input wire logic spi_mosi, // Serial data in, sampled on sclk rise
	output logic spi_miso, // Serial data out, changes on sclk rise
	input wire logic [3:0] din_cmp, // Raw input comparator outputs, asynchronous
	input wire logic [63:0] modem_alert_detail, // Modem status, 16 bits per channel
	input wire logic [63:0] modem_alert_masks, // Modem masks, 16 bits per channel
	input wire logic [63:0] chan_alert_detail, // Channel status, 16 bits per channel
	input wire logic [63:0] chan_alert_masks, // Channel masks, 16 bits per channel
	input wire logic [15:0] supply_alert_detail, // Supply status fields
	input wire logic [15:0] supply_alert_masks, // Supply masks
	input wire logic adc_error, // Converter error level
	input wire logic temp_at_limit, // Die temperature monitor level
	output logic alert_n, // Alert pin, active low
	output logic logic_reset, // One-cycle watchdog reset pulse
	output logic [15:0] slot_source // Effective source codes of slots 3..0
);
	// ****************************************
	// Functions
	// ****************************************
	function automatic logic [7:0] awdsr_crc8(input logic [31:0] d);
		logic [7:0] c;
		logic fb;
		c = 8'h00;
		for (int i = 31; i >= 0; i--) begin
			fb = c[7] ^ d[i];
			c = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
		end
		return c;
	endfunction

	function automatic logic [10:0] awdsr_interval(input logic [3:0] code);
		case (code)
			4'h0: return WD_T_1MS;
			4'h1: return WD_T_5MS;
			4'h2: return WD_T_10MS;
			4'h3: return WD_T_25MS;
			4'h4: return WD_T_50MS;
			4'h5: return WD_T_100MS;
			4'h6: return WD_T_250MS;
			4'h7: return WD_T_500MS;
			4'h8: return WD_T_750MS;
			4'h9: return WD_T_1S;
			4'ha: return WD_T_2S;
			default: return WD_T_1S;
		endcase
	endfunction

	// codes above the last defined one are grounded
	function automatic logic [3:0] awdsr_src(input logic [3:0] code);
		return (code > SRC_LAST) ? SRC_GROUND : code;
	endfunction

	// ****************************************
	// Serial clock domain
	// ****************************************
	logic armed;
	logic [5:0] bit_cnt;
	logic [39:0] rx_shift;
	logic [39:0] tx_shift;
	logic start_tgl;
	logic [39:0] resp_word;

	// Frame start marker, preset while select is high before the frame
	always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
		if (spi_cs_n) begin
			armed <= 1'b1;
		end else begin
			armed <= 1'b0;
		end
	end

	// Bit counter and shifters; hold still after the frame for the core to read
	always_ff @(posedge spi_sclk or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt <= 6'h00;
			rx_shift <= 40'h0;
			tx_shift <= 40'h0;
			start_tgl <= 1'b0;
			spi_miso <= 1'b0;
		end else begin
			rx_shift <= {rx_shift[38:0], spi_mosi};
			spi_miso <= armed ? resp_word[39] : tx_shift[39];
			tx_shift <= armed ? {resp_word[38:0], 1'b0} : {tx_shift[38:0], 1'b0};
			start_tgl <= armed ? !start_tgl : start_tgl;
			bit_cnt <= armed ? 6'h01 : ((bit_cnt == 6'h3f) ? bit_cnt : bit_cnt + 6'h01);
		end
	end

	// ****************************************
	// Crossing into the core domain
	// ****************************************
	logic cs_s1, cs_s2, cs_s3;
	logic tg_s1, tg_s2, tg_seen;

	// Two flops per level plus a third on select for its edge; select stages two and three feed logic
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			cs_s3 <= 1'b1;
			tg_s1 <= 1'b0;
			tg_s2 <= 1'b0;
		end else begin
			cs_s1 <= spi_cs_n;
			cs_s2 <= cs_s1;
			cs_s3 <= cs_s2;
			tg_s1 <= start_tgl;
			tg_s2 <= tg_s1;
		end
	end

	// Frame end: select rose and sclk toggled since the last frame
	wire frame_end = cs_s2 && !cs_s3 && (tg_s2 != tg_seen);
	// Counter and shifter are quiet once select is high, so reading them is safe
	wire [7:0] f_addr = rx_shift[31:24];
	wire [15:0] f_data = rx_shift[23:8];
	wire f_read = rx_shift[FRAME_RD_BIT];
	// exactly forty clocks and a matching check code
	wire f_count_ok = (bit_cnt == FRAME_BITS);
	wire f_crc_ok = (awdsr_crc8(rx_shift[39:8]) == rx_shift[7:0]);
	wire cmd_ok = frame_end && f_count_ok && f_crc_ok;
	wire cmd_bad = frame_end && !(f_count_ok && f_crc_ok);
	wire wr_en = cmd_ok && !f_read;

	// ****************************************
	// Registers
	// ****************************************
	logic [15:0] diag_sel;
	logic [4:0] wd_cfg;
	logic wd_flag;
	logic [15:0] deb_limit;
	logic [15:0] alert_sticky;
	logic [3:0] din_state;
	logic wd_run;
	logic [10:0] wd_ms;
	logic [16:0] wd_pre;

	wire wd_en = wd_cfg[WD_EN_BIT];
	wire [10:0] wd_limit = awdsr_interval(wd_cfg[3:0]);
	wire wd_tick = (wd_pre == 17'(TICK_CYCLES - 1));
	// expiry once the interval has passed without a good command
	wire wd_expire = wd_run && wd_en && wd_tick && (wd_ms == wd_limit - 11'h001) && !cmd_ok;

	wire sel_diag = wr_en && (f_addr == ADDR_DIAG_SEL);
	wire sel_wdc = wr_en && (f_addr == ADDR_WD_CFG);
	wire sel_wds = wr_en && (f_addr == ADDR_WD_STAT);
	wire sel_deb = wr_en && (f_addr == ADDR_DEB_CFG);
	wire sel_alert = wr_en && (f_addr == ADDR_ALERT);
	wire [15:0] alert_clr = sel_alert ? f_data : 16'h0000;

	// Summary levels from masked detail fields
	logic [3:0] modem_sum;
	logic [3:0] chan_sum;
	always_comb begin
		for (int ch = 0; ch < 4; ch++) begin
			modem_sum[ch] = |(modem_alert_detail[16*ch +: 16] & ~modem_alert_masks[16*ch +: 16]
				& ~MODEM_SKIP);
			chan_sum[ch] = |(chan_alert_detail[16*ch +: 16] & ~chan_alert_masks[16*ch +: 16]);
		end
	end
	wire supply_sum = |(supply_alert_detail & ~supply_alert_masks);

	// Sticky bits: the set term wins over a clear in the same cycle
	// converter error overheat serial fault set over clear
	wire [15:0] alert_set = {10'h000, adc_error, temp_at_limit, cmd_bad, 2'b00, wd_expire};
	wire [15:0] next_sticky = (alert_sticky & ~alert_clr) | alert_set;
	// reserved bits stay zero; live summary bits are not stored
	wire [15:0] alert_word = {modem_sum, chan_sum, 2'b00, alert_sticky[AL_ADC_BIT],
		alert_sticky[AL_TEMP_BIT], alert_sticky[AL_SPI_BIT], supply_sum, 1'b0,
		alert_sticky[AL_RESET_BIT]};

	// Control registers; a watchdog expiry puts them back to their reset state
	// slot fields enable bit interval default
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			diag_sel <= RST_DIAG_SEL;
			wd_cfg <= RST_WD_CFG;
			deb_limit <= RST_DEB_CFG;
		end else if (wd_expire) begin
			diag_sel <= RST_DIAG_SEL;
			wd_cfg <= RST_WD_CFG;
			deb_limit <= RST_DEB_CFG;
		end else begin
			diag_sel <= sel_diag ? f_data : diag_sel;
			wd_cfg <= sel_wdc ? f_data[4:0] : wd_cfg;
			deb_limit <= sel_deb ? f_data : deb_limit;
		end
	end

	// reset-occurred bit comes up set; expiry also reports it
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			alert_sticky <= 16'h0001;
			wd_flag <= 1'b0;
		end else begin
			alert_sticky <= next_sticky & 16'h0039;
			// flag raised on expiry host clears with a one
			wd_flag <= wd_expire || (wd_flag && !(sel_wds && f_data[0]));
		end
	end

	// running only after the first transaction following enable
	// every good command restarts the count on the core clock
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wd_run <= 1'b0;
			wd_ms <= 11'h000;
			wd_pre <= 17'h00000;
		end else if (!wd_en || wd_expire) begin
			wd_run <= 1'b0;
			wd_ms <= 11'h000;
			wd_pre <= 17'h00000;
		end else if (cmd_ok) begin
			wd_run <= 1'b1;
			wd_ms <= 11'h000;
			wd_pre <= 17'h00000;
		end else if (wd_run) begin
			wd_pre <= wd_tick ? 17'h00000 : wd_pre + 17'h00001;
			wd_ms <= wd_tick ? wd_ms + 11'h001 : wd_ms;
		end
	end

	// ****************************************
	// Input debounce
	// ****************************************
	logic [3:0] din_s1, din_s2;
	logic [15:0] deb_cnt [4];

	// Pins pass two flops before the filter looks at them
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			din_s1 <= 4'h0;
			din_s2 <= 4'h0;
		end else begin
			din_s1 <= din_cmp;
			din_s2 <= din_s1;
		end
	end

	// a new level must hold for the programmed count before it is taken
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			din_state <= 4'h0;
			for (int ch = 0; ch < 4; ch++) deb_cnt[ch] <= 16'h0000;
		end else begin
			for (int ch = 0; ch < 4; ch++) begin
				if (din_s2[ch] == din_state[ch]) begin
					deb_cnt[ch] <= 16'h0000;
				end else if (deb_cnt[ch] >= deb_limit) begin
					din_state[ch] <= din_s2[ch];
					deb_cnt[ch] <= 16'h0000;
				end else begin
					deb_cnt[ch] <= deb_cnt[ch] + 16'h0001;
				end
			end
		end
	end

	// ****************************************
	// Read data, reply word and outputs
	// ****************************************
	logic [15:0] rd_data;
	always_comb begin
		case (f_addr)
			ADDR_DIAG_SEL: rd_data = diag_sel;
			ADDR_WD_CFG: rd_data = {11'h000, wd_cfg};
			ADDR_WD_STAT: rd_data = {15'h0000, wd_flag};
			ADDR_DEB_CFG: rd_data = deb_limit;
			// channels A to D in bits 0 to 3
			ADDR_DIN_STATE: rd_data = {12'h000, din_state};
			ADDR_ALERT: rd_data = alert_word;
			default: rd_data = 16'h0000;
		endcase
	end
	wire [31:0] resp_body = {8'h00, f_addr, rd_data};

	// Reply shifts out in the next frame; loaded only between frames
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			resp_word <= 40'h0;
			tg_seen <= 1'b0;
		end else if (frame_end) begin
			resp_word <= {resp_body, awdsr_crc8(resp_body)};
			tg_seen <= tg_s2;
		end
	end

	// codes pass through, undefined ones grounded
	wire [15:0] next_src = {awdsr_src(diag_sel[15:12]), awdsr_src(diag_sel[11:8]),
		awdsr_src(diag_sel[7:4]), awdsr_src(diag_sel[3:0])};
	// any set summary bit pulls the pin
	wire [15:0] next_alert_word = {modem_sum, chan_sum, 2'b00, next_sticky[5:3], supply_sum,
		1'b0, next_sticky[0]};
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			slot_source <= 16'h0000;
			logic_reset <= 1'b0;
			alert_n <= 1'b1;
		end else begin
			slot_source <= next_src;
			logic_reset <= wd_expire;
			alert_n <= !(|next_alert_word);
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence s_expiry;
		wd_expire ##1 logic_reset;
	endsequence

	a_expiry_resets: assert property (s_expiry |-> wd_flag && !wd_en && alert_sticky[0])
		else $error("watchdog expiry did not reset control and raise flag");
	a_wd_flag_clear: assert property (wd_flag && sel_wds && f_data[0] && !wd_expire |=> !wd_flag)
		else $error("watchdog flag not cleared by write of one");
	a_wd_idle_off: assert property (!wd_en |=> !wd_run && wd_ms == 11'h000)
		else $error("watchdog counted while disabled");
	a_wd_restart: assert property (cmd_ok && wd_en && !wd_expire |=> wd_run && wd_ms == 11'h000)
		else $error("good command did not restart the interval");
	// Reserved config bits checked in the reply word that the host really sees
	a_cfg_reserved: assert property (frame_end && f_addr == ADDR_WD_CFG |=>
		resp_word[23:13] == 11'h000)
		else $error("watchdog config reserved bits not zero");
	a_slot_ground: assert property (diag_sel[3:0] > SRC_LAST |=> slot_source[3:0] == SRC_GROUND)
		else $error("undefined slot code not grounded");
	a_sticky_set: assert property (adc_error |=> alert_sticky[AL_ADC_BIT] && !alert_n)
		else $error("converter error did not stick or reach the pin");
	a_spi_fault: assert property (cmd_bad |=> alert_sticky[AL_SPI_BIT])
		else $error("bad frame did not raise serial fault");
	a_w1c_clear: assert property (sel_alert && f_data[4] && !temp_at_limit |=> !alert_sticky[4])
		else $error("overheat flag not cleared by write of one");
	// Supply summary and reserved bits 7:6 as they leave in the reply
	a_supply_sum: assert property (frame_end && f_addr == ADDR_ALERT |=>
		resp_word[10] == $past(supply_sum) && resp_word[15:14] == 2'b00)
		else $error("supply summary or reserved alert bits wrong");
	// Pin is registered, so it lags the live summary inputs by one cycle
	a_pin_follows: assert property ($past(rst_n) |-> alert_n == !(|{$past(modem_sum),
		$past(chan_sum), $past(supply_sum), alert_sticky[5:3], alert_sticky[AL_RESET_BIT]}))
		else $error("alert pin disagrees with summary");
endmodule

// ### awdsr_host.sv
// Serial host model that frames commands for the register bank
`timescale 1ns/10ps
module awdsr_host
	import awdsr_pkg::*;
(
	output logic spi_sclk, // Serial clock, runs only inside frames
	output logic spi_cs_n, // Frame select, active low
	output logic spi_mosi, // Serial data to the device
	input wire logic spi_miso // Serial data from the device
);
	// Lines idle before the first frame
	initial begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b0;
	end
	// ****************************************
	// Framing
	// ****************************************
	// Check code over the 32 leading bits, MSB first
	function automatic logic [7:0] crc8(input logic [31:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 31; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
		end
		return c;
	endfunction
	// One frame; the odd gap keeps sclk unrelated to the core clock
	task automatic xfer(input logic rd, input logic [7:0] a, input logic [15:0] d,
		input int nclk, input logic [7:0] flip, output logic [39:0] rx);
		logic [39:0] w;
		w = {rd, 7'h00, a, d, 8'h00};
		w[7:0] = crc8(w[39:8]) ^ flip;
		rx = 40'h0;
		#113;
		spi_cs_n = 1'b0;
		#20;
		for (int i = 0; i < nclk; i++) begin
			spi_mosi = w[39 - i];
			#32 spi_sclk = 1'b1;
			#32 spi_sclk = 1'b0;
			rx[39 - i] = spi_miso;
		end
		#20;
		spi_cs_n = 1'b1;
		// Released data line shows the inverse, not a stale copy
		spi_mosi = ~spi_mosi;
	endtask
endmodule

// ### awdsr_regs_bench.sv
// Self-checking bench for the alert, watchdog and diagnostic select registers
`timescale 1ns/10ps
module awdsr_regs_bench;
	import awdsr_pkg::*;
	localparam int TICKS = 10;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, alert_n, logic_reset;
	logic [3:0] din_cmp = 4'h0;
	logic [63:0] modem_alert_detail = 64'h0, modem_alert_masks = 64'h0;
	logic [63:0] chan_alert_detail = 64'h0, chan_alert_masks = 64'h0;
	logic [15:0] supply_alert_detail = 16'h0, supply_alert_masks = 16'h0;
	logic adc_error = 1'b0, temp_at_limit = 1'b0;
	logic [15:0] slot_source;
	logic [39:0] rx_word;
	logic [15:0] pulses = 16'h0000;
	int failures = 0, total_checks = 0;
	// Core clock, 8 ns
	always #4 core_clk = ~core_clk;
	// Count watchdog pulses to catch a start at the enabling write
	always @(negedge core_clk) if (logic_reset === 1'b1) pulses <= pulses + 16'h0001;
	awdsr_regs #(.TICK_CYCLES(TICKS), .MODEM_SKIP(MODEM_IGNORE)) uut (.core_clk(core_clk),
		.rst_n(rst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
		.spi_miso(spi_miso), .din_cmp(din_cmp), .modem_alert_detail(modem_alert_detail),
		.modem_alert_masks(modem_alert_masks), .chan_alert_detail(chan_alert_detail),
		.chan_alert_masks(chan_alert_masks), .supply_alert_detail(supply_alert_detail),
		.supply_alert_masks(supply_alert_masks), .adc_error(adc_error),
		.temp_at_limit(temp_at_limit), .alert_n(alert_n), .logic_reset(logic_reset),
		.slot_source(slot_source));
	awdsr_host host (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
		.spi_miso(spi_miso));
	// ****************************************
	// Helpers
	// ****************************************
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		host.xfer(1'b0, a, d, 40, 8'h00, rx_word);
	endtask
	// Reply arrives in the following frame
	task automatic rdchk(input string name, input logic [7:0] a, input logic [15:0] exp);
		host.xfer(1'b1, a, 16'h0000, 40, 8'h00, rx_word);
		host.xfer(1'b1, ADDR_DIN_STATE, 16'h0000, 40, 8'h00, rx_word);
		check({name, " addr"}, {8'h00, rx_word[31:24]}, {8'h00, a});
		check(name, rx_word[23:8], exp);
	endtask
	// Enable, prove idle until a frame, then time the expiry after kicks
	task automatic wd_run(input logic [3:0] code, input int ticks, input int mid);
		logic [15:0] p0;
		int n;
		wr(ADDR_WD_CFG, {11'h000, 1'b1, code});
		p0 = pulses;
		repeat (ticks * TICKS + 40) @(negedge core_clk);
		check("idle until first frame", pulses, p0);
		host.xfer(1'b1, ADDR_DIN_STATE, 16'h0000, 40, 8'h00, rx_word);
		if (mid > 0) begin
			repeat (mid) @(negedge core_clk);
			host.xfer(1'b1, ADDR_DIN_STATE, 16'h0000, 40, 8'h00, rx_word);
		end
		n = 0;
		while (logic_reset !== 1'b1 && n < 30000) begin
			@(negedge core_clk);
			n++;
		end
		check("expiry time", {15'h0, n >= ticks * TICKS - 1 && n <= ticks * TICKS + 8}, 16'h1);
		@(negedge core_clk);
		check("reset pulse width", {15'h0, logic_reset}, 16'h0000);
		rdchk("config after expiry", ADDR_WD_CFG, 16'h0009);
		rdchk("expired flag", ADDR_WD_STAT, 16'h0001);
		wr(ADDR_WD_STAT, 16'h0001);
		rdchk("flag cleared", ADDR_WD_STAT, 16'h0000);
		wr(ADDR_ALERT, 16'h0001);
	endtask
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		repeat (3) @(negedge core_clk);
		rst_n = 1'b1;
		repeat (2) @(negedge core_clk);
		check("alert pin after reset", {15'h0, alert_n}, 16'h0000);
		rdchk("diag reset", ADDR_DIAG_SEL, 16'h0000);
		rdchk("config reset", ADDR_WD_CFG, 16'h0009);
		rdchk("inputs reset", ADDR_DIN_STATE, 16'h0000);
		rdchk("alert reset", ADDR_ALERT, 16'h0001);
		wr(ADDR_ALERT, 16'h0001);
		rdchk("reset bit cleared", ADDR_ALERT, 16'h0000);
		check("alert pin idle", {15'h0, alert_n}, 16'h0001);
		$display("test reset_values done");
		for (int c = 0; c < 16; c++) begin
			wr(ADDR_DIAG_SEL, {4{c[3:0]}});
			rdchk("slot fields", ADDR_DIAG_SEL, {4{c[3:0]}});
			check("slot source", slot_source, (c > 13) ? 16'h0 : {4{c[3:0]}});
		end
		wr(ADDR_DIAG_SEL, 16'hda1e);
		rdchk("mixed fields", ADDR_DIAG_SEL, 16'hda1e);
		check("mixed source", slot_source, 16'hda10);
		$display("test diag_select done");
		wr(ADDR_WD_CFG, 16'hffe3);
		rdchk("config reserved", ADDR_WD_CFG, 16'h0003);
		wd_run(4'h0, 1, 0);
		wd_run(4'h5, 100, 600);
		wd_run(4'hf, 1000, 0);
		$display("test watchdog done");
		@(negedge core_clk);
		modem_alert_detail = 64'h0010_0001_0000_0000;
		chan_alert_detail = 64'h0000_0000_0008_0080;
		chan_alert_masks = 64'h0000_0000_0000_0080;
		supply_alert_detail = 16'h0020;
		rdchk("summary unmasked", ADDR_ALERT, 16'h8204);
		check("alert pin on summary", {15'h0, alert_n}, 16'h0000);
		@(negedge core_clk);
		modem_alert_masks = 64'h0010_0000_0000_0000;
		chan_alert_masks = 64'h0000_0000_0008_0080;
		supply_alert_masks = 16'h0020;
		rdchk("summary masked", ADDR_ALERT, 16'h0000);
		check("alert pin masked", {15'h0, alert_n}, 16'h0001);
		$display("test summaries done");
		@(negedge core_clk);
		adc_error = 1'b1;
		temp_at_limit = 1'b1;
		@(negedge core_clk);
		adc_error = 1'b0;
		rdchk("sticky errors", ADDR_ALERT, 16'h0030);
		wr(ADDR_ALERT, 16'h00f0);
		rdchk("persisting cause", ADDR_ALERT, 16'h0010);
		@(negedge core_clk);
		temp_at_limit = 1'b0;
		wr(ADDR_ALERT, 16'h0010);
		rdchk("sticky cleared", ADDR_ALERT, 16'h0000);
		for (int k = 0; k < 2; k++) begin
			host.xfer(1'b0, ADDR_DIAG_SEL, 16'h1234, 39 + k, 8'(k), rx_word);
			rdchk("serial fault", ADDR_ALERT, 16'h0008);
			// Slot fields were put back to zero by the earlier expiries
			rdchk("bad frame no write", ADDR_DIAG_SEL, 16'h0000);
			wr(ADDR_ALERT, 16'h0008);
		end
		$display("test sticky_flags done");
		// Long debounce so a read lands before the new level is taken
		wr(ADDR_DEB_CFG, 16'h0400);
		rdchk("debounce count", ADDR_DEB_CFG, 16'h0400);
		@(negedge core_clk);
		din_cmp = 4'h5;
		rdchk("debounce holds", ADDR_DIN_STATE, 16'h0000);
		repeat (1100) @(negedge core_clk);
		rdchk("debounced inputs", ADDR_DIN_STATE, 16'h0005);
		din_cmp = 4'ha;
		repeat (1100) @(negedge core_clk);
		rdchk("debounced inputs", ADDR_DIN_STATE, 16'h000a);
		wr(8'h10, 16'hffff);
		rdchk("unmapped", 8'h10, 16'h0000);
		$display("test inputs done");
		end_of_test();
	end
	// Cut a hang short well beyond the expected run
	initial begin
		#700000;
		failures++;
		end_of_test();
	end
endmodule
